// *** udc4_pkg.sv ***
// Constants shared by the up/down cascadable counter and its register slave.
// Assumes a single 32-bit AHB-Lite slave port with word-aligned registers.
package udc4_pkg;

    // Counter geometry and values.
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ALL_ONES = 4'hf;

    // Bus geometry.
    localparam int DATA_W = 32;
    localparam int ADDR_DEC_W = 8;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic HREADY_RST = 1'b1;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // Register byte offsets.
    localparam logic [ADDR_DEC_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_DEC_W-1:0] ADDR_PRESET = 8'h04;
    localparam logic [ADDR_DEC_W-1:0] ADDR_STATUS = 8'h08;

    // Control register: write-one command bits, read back as pending.
    localparam int CTRL_W = 3;
    localparam int CTRL_LOAD_BIT = 0;
    localparam int CTRL_UP_BIT = 1;
    localparam int CTRL_DOWN_BIT = 2;

    // Status register layout: count in the low bits, then the flags.
    localparam int STAT_W = 8;
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_UP_FLAG_BIT = 4;
    localparam int STAT_DOWN_FLAG_BIT = 5;
    localparam int STAT_UP_CARRY_BIT = 6;
    localparam int STAT_DOWN_CARRY_BIT = 7;

endpackage : udc4_pkg

// *** udc4_stage.sv ***
// One loadable bidirectional counter stage with terminal and carry gates.
// Assumes load has priority over counting and that clear_n is asynchronous.
`timescale 1ns/100ps
`default_nettype none

module udc4_stage
    import udc4_pkg::*;
(
    // Clock, clear and freeze.
    input wire logic clk,
    input wire logic clear_n,
    input wire logic ce,
    // Counting controls.
    input wire logic load,
    input wire logic up_en,
    input wire logic down_en,
    input wire logic [CNT_W-1:0] load_data,
    // Count and flags.
    output logic [CNT_W-1:0] count,
    output logic up_flag,
    output logic down_flag,
    output logic up_carry,
    output logic down_carry
);

    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] count_inc;
    logic [CNT_W-1:0] count_dec;

    // Both enables high falls through to the increment branch.
    assign count_inc = count + CNT_ONE;
    assign count_dec = count - CNT_ONE;
    assign next_count = load ? load_data :
                        up_en ? count_inc :
                        down_en ? count_dec :
                        count;

    // Every stage updates on the same edge; nothing ripples between stages.
    always_ff @(posedge clk or negedge clear_n)
    begin
        if (!clear_n)
        begin
            count <= CNT_ZERO;
        end
        else if (ce)
        begin
            count <= next_count;
        end
    end

    // Plain gates so a chained stage sees its enable in the same cycle.
    assign up_flag = (count == CNT_ALL_ONES);
    assign down_flag = (count == CNT_ZERO);
    assign up_carry = up_flag & up_en;
    assign down_carry = down_flag & down_en;

endmodule // udc4_stage
`default_nettype wire

// *** udc4_counter.sv ***
// Top of the cascadable up/down counter with an AHB-Lite register slave.
// Assumes the pin inputs are synchronous to clk and that neighbouring
// stages share clk, load and clear, as the cascade expects.
//
// Operation
// - Four-bit loadable, clearable, bidirectional synchronous counter.
// - Clear high forces zero and flags immediately.
// - Load copies preset on edge, ignoring enables.
// - Up enable increments count on edge.
// - Down enable decrements count on edge.
// - No enable, no load: count holds.
// - Up carry: all ones and up enable.
// - Down carry: all zeros and down enable.
// - Up flag: all ones, enable ignored.
// - Down flag: all zeros, enable ignored.
// - Flag and carries are ungated combinational ANDs.
// - Reset gives zero count, flags low/high.
// - All stages update in one clock.
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module udc4_counter
    import udc4_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Counter controls from neighbouring logic.
    input wire logic async_zeroing_input,
    input wire logic load_strobe,
    input wire logic up_count_enable,
    input wire logic down_count_enable,
    input wire logic [CNT_W-1:0] preset_value,
    // Counter results.
    output logic [CNT_W-1:0] count_value,
    output logic up_terminal_flag,
    output logic down_terminal_flag,
    output logic up_carry_out,
    output logic down_carry_out,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [DATA_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [DATA_W-1:0] hrdata
);

    logic rst_meta;
    logic rst_sync;
    logic dp_write;
    logic [ADDR_DEC_W-1:0] dp_addr;
    logic pend_load;
    logic pend_up;
    logic pend_down;
    logic [CNT_W-1:0] preset_reg;
    logic [DATA_W-1:0] next_hrdata;

    // Reset release through two flops; assertion is immediate.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // The pin clear bypasses the clock, so it joins the reset net directly.
    // A glitch on that pin will clear the count; drive it cleanly.
    wire clear_n = rst_sync & ~async_zeroing_input;

    // Software commands merge with the pins; software load uses its own
    // preset register so a pin preset cannot corrupt it.
    wire load_eff = load_strobe | pend_load;
    wire up_eff = up_count_enable | pend_up;
    wire down_eff = down_count_enable | pend_down;
    wire [CNT_W-1:0] load_data = pend_load ? preset_reg : preset_value;

    udc4_stage u_stage (
        .clk(clk),
        .clear_n(clear_n),
        .ce(ce),
        .load(load_eff),
        .up_en(up_eff),
        .down_en(down_eff),
        .load_data(load_data),
        .count(count_value),
        .up_flag(up_terminal_flag),
        .down_flag(down_terminal_flag),
        .up_carry(up_carry_out),
        .down_carry(down_carry_out)
    );

    // Bus address phase and decode.
    wire addr_phase = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
    wire rd_phase = addr_phase & ~hwrite;
    wire [ADDR_DEC_W-1:0] a_addr = haddr[ADDR_DEC_W-1:0];
    wire wr_ctrl = dp_write & (dp_addr == ADDR_CTRL);
    wire wr_preset = dp_write & (dp_addr == ADDR_PRESET);

    wire set_load = wr_ctrl & hwdata[CTRL_LOAD_BIT];
    wire set_up = wr_ctrl & hwdata[CTRL_UP_BIT];
    wire set_down = wr_ctrl & hwdata[CTRL_DOWN_BIT];

    // A command waits while the block is frozen; a new write wins over
    // the consumption in the same cycle so no request is lost.
    wire next_pend_load = set_load | (pend_load & ~ce);
    wire next_pend_up = set_up | (pend_up & ~ce);
    wire next_pend_down = set_down | (pend_down & ~ce);

    wire [CTRL_W-1:0] ctrl_word = {pend_down, pend_up, pend_load};
    wire [STAT_W-1:0] stat_word = {down_carry_out, up_carry_out,
                                   down_terminal_flag, up_terminal_flag,
                                   count_value};
    wire [DATA_W-1:0] rd_ctrl = {{(DATA_W-CTRL_W){1'b0}}, ctrl_word};
    wire [DATA_W-1:0] rd_preset = {{(DATA_W-CNT_W){1'b0}}, preset_reg};
    wire [DATA_W-1:0] rd_status = {{(DATA_W-STAT_W){1'b0}}, stat_word};

    // Unmapped offsets read as zero and ignore writes.
    assign next_hrdata = (a_addr == ADDR_CTRL) ? rd_ctrl :
                         (a_addr == ADDR_PRESET) ? rd_preset :
                         (a_addr == ADDR_STATUS) ? rd_status :
                         RDATA_RST;

    // The bus slave keeps running while ce is low so software never hangs.
    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            dp_write <= 1'b0;
            dp_addr <= ADDR_CTRL;
        end
        else
        begin
            dp_write <= addr_phase & hwrite;
            dp_addr <= a_addr;
        end
    end

    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            pend_load <= 1'b0;
            pend_up <= 1'b0;
            pend_down <= 1'b0;
        end
        else
        begin
            pend_load <= next_pend_load;
            pend_up <= next_pend_up;
            pend_down <= next_pend_down;
        end
    end

    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            preset_reg <= CNT_ZERO;
        end
        else if (wr_preset)
        begin
            preset_reg <= hwdata[CNT_W-1:0];
        end
    end

    // Read data is captured at the end of the address phase, which gives
    // zero wait states at the cost of a snapshot one cycle old.
    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            hrdata <= RDATA_RST;
        end
        else if (rd_phase)
        begin
            hrdata <= next_hrdata;
        end
    end

    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            hreadyout <= HREADY_RST;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            hreadyout <= HREADY_RST;
            hresp <= HRESP_OKAY;
        end
    end

    // Checks on the counter and bus behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync);

    wire run_load = ce & load_eff & ~async_zeroing_input;
    wire run_up = ce & ~load_eff & up_eff & ~down_eff & ~async_zeroing_input;
    wire run_down = ce & ~load_eff & ~up_eff & down_eff &
                    ~async_zeroing_input;
    wire run_both = ce & ~load_eff & up_eff & down_eff &
                    ~async_zeroing_input;
    wire run_hold = ~load_eff & ~up_eff & ~down_eff & ~async_zeroing_input;

    clear_forces_a: assert property (
        async_zeroing_input |-> (count_value == CNT_ZERO) &&
            !up_terminal_flag && down_terminal_flag && !up_carry_out)
        else $error("clear did not force zero and flags");

    load_copy_a: assert property (
        run_load ##1 !async_zeroing_input |->
            count_value == $past(load_data))
        else $error("load did not copy preset");

    up_step_a: assert property (
        run_up ##1 !async_zeroing_input |->
            count_value == CNT_W'($past(count_value) + CNT_ONE))
        else $error("up count did not add one");

    down_step_a: assert property (
        run_down ##1 !async_zeroing_input |->
            count_value == CNT_W'($past(count_value) - CNT_ONE))
        else $error("down count did not subtract one");

    hold_count_a: assert property (
        run_hold ##1 !async_zeroing_input |-> $stable(count_value))
        else $error("count changed with no enable");

    both_inc_a: assert property (
        run_both ##1 !async_zeroing_input |->
            count_value == CNT_W'($past(count_value) + CNT_ONE))
        else $error("both enables did not increment");

    up_carry_a: assert property (
        up_carry_out == ((count_value == CNT_ALL_ONES) && up_eff))
        else $error("up carry wrong");

    down_carry_a: assert property (
        down_carry_out == ((count_value == CNT_ZERO) && down_eff))
        else $error("down carry wrong");

    up_flag_a: assert property (
        (count_value == CNT_ALL_ONES) |-> up_terminal_flag &&
            !down_terminal_flag)
        else $error("up flag missing at all ones");

    down_flag_a: assert property (
        down_terminal_flag |-> (count_value == CNT_ZERO) &&
            !up_carry_out)
        else $error("down flag without zero count");

    wrap_up_a: assert property (
        run_up && up_carry_out ##1 !async_zeroing_input |->
            down_terminal_flag)
        else $error("up wrap did not reach zero");

    wrap_down_a: assert property (
        run_down && down_carry_out ##1 !async_zeroing_input |->
            up_terminal_flag)
        else $error("down wrap did not reach all ones");

    reset_state_a: assert property (
        $rose(rst_sync) |-> (count_value == CNT_ZERO) &&
            down_terminal_flag && !up_terminal_flag)
        else $error("count not zero after reset");

    sw_load_a: assert property (
        wr_ctrl && hwdata[CTRL_LOAD_BIT] ##1 ce && !async_zeroing_input
            ##1 !async_zeroing_input |-> count_value == $past(preset_reg))
        else $error("software load did not copy preset register");

    bus_okay_a: assert property (
        hreadyout && (hresp == HRESP_OKAY))
        else $error("slave stalled or answered an error");

    up_flag_only_a: assert property (
        up_terminal_flag |-> (count_value == CNT_ALL_ONES))
        else $error("up flag without all ones count");

    zero_flag_a: assert property (
        (count_value == CNT_ZERO) |-> down_terminal_flag &&
            !up_terminal_flag)
        else $error("down flag missing at zero count");

    carry_clear_a: assert property (
        async_zeroing_input |-> !up_carry_out &&
            (down_carry_out == down_eff))
        else $error("carries wrong while clear is high");

    freeze_hold_a: assert property (
        !ce && !async_zeroing_input ##1 !async_zeroing_input |->
            $stable(count_value))
        else $error("count moved while frozen");

    pend_wait_a: assert property (
        !ce |=> ((ctrl_word & $past(ctrl_word)) == $past(ctrl_word)))
        else $error("pending command lost while frozen");

    pend_consume_a: assert property (
        ce && !wr_ctrl |=> !pend_load && !pend_up && !pend_down)
        else $error("software command applied more than once");

    preset_write_a: assert property (
        wr_preset |=> preset_reg == $past(hwdata[CNT_W-1:0]))
        else $error("preset register write lost");

    status_read_a: assert property (
        rd_phase && (a_addr == ADDR_STATUS) |=>
            hrdata[STAT_COUNT_LSB +: CNT_W] == $past(count_value) &&
            hrdata[STAT_UP_FLAG_BIT] == $past(up_terminal_flag) &&
            hrdata[STAT_DOWN_FLAG_BIT] == $past(down_terminal_flag) &&
            hrdata[STAT_UP_CARRY_BIT] == $past(up_carry_out) &&
            hrdata[STAT_DOWN_CARRY_BIT] == $past(down_carry_out))
        else $error("status read does not match the counter");

    unmapped_read_a: assert property (
        rd_phase && (a_addr != ADDR_CTRL) && (a_addr != ADDR_PRESET) &&
            (a_addr != ADDR_STATUS) |=> hrdata == RDATA_RST)
        else $error("unmapped read returned data");

    load_seen_c: cover property (run_load ##1 ce);
    wrap_up_c: cover property (run_up && up_carry_out ##1 down_terminal_flag);
    wrap_down_c: cover property (run_down && down_carry_out);
    sw_cmd_c: cover property (wr_ctrl ##1 pend_up ##1 !pend_up);
    clear_c: cover property ($rose(async_zeroing_input));

endmodule // udc4_counter
`default_nettype wire

// *** udc4_neighbour.sv ***
// Behavioural next stage of a counter chain, fed by the carry outputs.
// Assumes it shares clock, load and clear with the stage it follows.
`timescale 1ns/100ps
`default_nettype none

module udc4_neighbour
    import udc4_pkg::*;
(
    // Shared controls.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic load,
    // Enables taken from the previous stage.
    input wire logic up_en,
    input wire logic down_en,
    // Count and terminal flags.
    output logic [CNT_W-1:0] count,
    output logic up_flag,
    output logic down_flag
);
    // Its preset is zero, so a shared load empties this stage.
    always_ff @(posedge clk or negedge reset_n or posedge clear)
    begin
        if (!reset_n || clear)
            count <= CNT_ZERO;
        else if (load)
            count <= CNT_ZERO;
        else if (up_en)
            count <= count + CNT_ONE;
        else if (down_en)
            count <= count - CNT_ONE;
    end
    assign up_flag = (count == CNT_ALL_ONES);
    assign down_flag = (count == CNT_ZERO);
endmodule // udc4_neighbour
`default_nettype wire

// *** updown_cascade_counter4_tb.sv ***
// Self-checking bench for the cascadable counter with a chained stage.
// Assumes zero-wait AHB-Lite answers and combinational flags and carries.
`timescale 1ns/100ps
`default_nettype none

module updown_cascade_counter4_tb;
    import udc4_pkg::*;
    logic clk = 1'b0;
    logic reset_n;
    logic ce = 1'b1;
    logic async_zeroing_input = 1'b0;
    logic load_strobe = 1'b0;
    logic up_count_enable = 1'b0;
    logic down_count_enable = 1'b0;
    logic [CNT_W-1:0] preset_value = 4'h0;
    logic hsel = 1'b0;
    logic [DATA_W-1:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [DATA_W-1:0] hwdata = 32'h0;
    logic [CNT_W-1:0] count_value, nb_count, exp;
    logic up_terminal_flag, down_terminal_flag, up_carry_out, down_carry_out;
    logic hreadyout, hresp, nb_up, nb_dn;
    logic [DATA_W-1:0] hrdata, rd;
    int checks = 0;
    int fail_count = 0;
    int cycles = 0;

    udc4_counter dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
        .async_zeroing_input(async_zeroing_input),
        .load_strobe(load_strobe), .up_count_enable(up_count_enable),
        .down_count_enable(down_count_enable), .preset_value(preset_value),
        .count_value(count_value), .up_terminal_flag(up_terminal_flag),
        .down_terminal_flag(down_terminal_flag), .up_carry_out(up_carry_out),
        .down_carry_out(down_carry_out), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    udc4_neighbour nb_u (.clk(clk), .reset_n(reset_n),
        .clear(async_zeroing_input), .load(load_strobe),
        .up_en(up_carry_out), .down_en(down_carry_out), .count(nb_count),
        .up_flag(nb_up), .down_flag(nb_dn));

    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] want, got);
        checks++;
        if (got !== want)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, want, got);
        end
    endtask

    // Inputs change after an edge; outputs are looked at mid-cycle.
    task automatic step(input logic ld, up, dn, input logic [3:0] pv);
        @(posedge clk);
        load_strobe <= ld;
        up_count_enable <= up;
        down_count_enable <= dn;
        preset_value <= pv;
        @(negedge clk);
        chk("count", 32'(exp), 32'(count_value));
        chk("up flag", 32'(exp == 4'hf), 32'(up_terminal_flag));
        chk("down flag", 32'(exp == 4'h0), 32'(down_terminal_flag));
        if (ce && !(up && dn))
        begin
            chk("up carry", 32'(exp == 4'hf && up), 32'(up_carry_out));
            chk("dn carry", 32'(exp == 4'h0 && dn), 32'(down_carry_out));
        end
        if (ce && !async_zeroing_input)
            exp = ld ? pv : up ? exp + 4'h1 : dn ? exp - 4'h1 : exp;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    initial
    begin
        reset_n <= 1'b0;
        exp = 4'h0;
        repeat (5) @(posedge clk);
        chk("reset state", 32'h2,
            {30'h0, down_terminal_flag, up_terminal_flag});
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        step(1'b0, 1'b0, 1'b0, 4'h0);
        step(1'b1, 1'b1, 1'b0, 4'he);
        step(1'b0, 1'b1, 1'b0, 4'h0);
        step(1'b0, 1'b1, 1'b0, 4'h0);
        step(1'b0, 1'b0, 1'b1, 4'h0);
        chk("chain up", 32'h1, 32'(nb_count));
        step(1'b0, 1'b0, 1'b0, 4'h0);
        chk("chain down", 32'h0, 32'(nb_count));
        chk("chain flag", 32'h0, 32'(up_terminal_flag & nb_up));
        step(1'b0, 1'b0, 1'b0, 4'h0);
        step(1'b0, 1'b1, 1'b1, 4'h0);
        step(1'b0, 1'b0, 1'b1, 4'h0);
        step(1'b0, 1'b0, 1'b1, 4'h0);
        step(1'b0, 1'b0, 1'b0, 4'h0);
        @(posedge clk) ce <= 1'b0;
        step(1'b0, 1'b1, 1'b0, 4'h0);
        step(1'b0, 1'b0, 1'b0, 4'h0);
        @(posedge clk) ce <= 1'b1;
        step(1'b0, 1'b0, 1'b0, 4'h0);
        @(posedge clk) async_zeroing_input <= 1'b1;
        #5;
        exp = 4'h0;
        chk("async clear", 32'h20,
            {26'h0, down_terminal_flag, up_terminal_flag, count_value});
        step(1'b1, 1'b1, 1'b0, 4'h5);
        step(1'b0, 1'b0, 1'b0, 4'h0);
        @(posedge clk) async_zeroing_input <= 1'b0;
        step(1'b0, 1'b0, 1'b0, 4'h0);
        ahb(1'b0, ADDR_PRESET, 32'h0);
        chk("preset reset", 32'h0, rd);
        ahb(1'b1, ADDR_PRESET, 32'h9);
        ahb(1'b0, ADDR_PRESET, 32'h0);
        chk("preset", 32'h9, rd);
        ahb(1'b1, ADDR_CTRL, 32'h1);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("status load", 32'h9, rd);
        ahb(1'b1, ADDR_CTRL, 32'h2);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("status up", 32'ha, rd);
        ahb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, rd);
        @(posedge clk) ce <= 1'b0;
        ahb(1'b1, ADDR_CTRL, 32'h4);
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk("pending down", 32'h4, rd);
        @(posedge clk) ce <= 1'b1;
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("status down", 32'h9, rd);
        ahb(1'b1, ADDR_PRESET, 32'hf);
        ahb(1'b1, ADDR_CTRL, 32'h1);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("status ones", 32'h1f, rd);
        chk("response", 32'(HRESP_OKAY), 32'(hresp));
        chk("ready", 32'h1, 32'(hreadyout));
        @(posedge clk) reset_n <= 1'b0;
        @(negedge clk);
        chk("master reset", 32'h20,
            {26'h0, down_terminal_flag, up_terminal_flag, count_value});
        @(posedge clk) reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        ahb(1'b0, ADDR_PRESET, 32'h0);
        chk("preset cleared", 32'h0, rd);
        end_of_test();
    end
endmodule // updown_cascade_counter4_tb
`default_nettype wire
